// ===== design/ref_select_divider_regs.v
`timescale 1ns/1ns
`include "ref_select_divider_regs_defs.vh"

// Functional notes
// [R1] Commit bit copies all buffers to active
// [R2] Commit acts live and self-clears
// [R3] Host writes commit bits 7:1 as zero
// [R4] Eight-bit reference ratio, resets to one
// [R5] Restart bit resets divider live, self-clears
// [R6] Override set: pin high first, low second
// [R7] Override clear: soft bit picks reference
// [R8] Host writes control bits 7:3 as zero
// [R9] First termination two bits, resets 01
// [R10] First regulator and input on, default 07
// [R11] Second termination same encoding, resets 01
// [R12] Second regulator on, input off, default 06
// [R13] Host writes reference config 7:4 zero
// [R14] Output one ratio; zero disables; resets one
// [R15] Non-live fields act after commit only
module ref_select_divider_regs (
  // Clock and reset
  input  wire       MCLK,
  input  wire       ARST_N,
  // Serial control port
  input  wire       SCLK,
  input  wire       CS_N,
  input  wire       SDI,
  output reg        SDO,
  output reg        SDO_OE,
  // Reference pins
  input  wire       REF_SEL,
  input  wire       FIRST_REF_IN,
  input  wire       SECOND_REF_IN,
  // Active configuration
  output reg  [7:0] REF_DIVIDE_RATIO,
  output reg        FIRST_REFERENCE_SELECTED,
  output reg  [1:0] FIRST_REF_TERMINATION,
  output reg        FIRST_REF_REGULATOR_ON,
  output reg        FIRST_REF_ON,
  output reg  [1:0] SECOND_REF_TERMINATION,
  output reg        SECOND_REF_REGULATOR_ON,
  output reg        SECOND_REF_ON,
  output reg  [7:0] OUTPUT_ONE_DIVIDE_RATIO,
  output reg        OUTPUT_ONE_DIV_ENABLE,
  // Events
  output reg        COMMIT_PULSE,
  output reg        REF_DIVIDER_RESTART,
  output reg        REF_DIV_TICK
);

  // ========================================================
  // Pin synchronisers
  wire        sclk_sync;
  wire        cs_n_sync;
  wire        sdi_sync;
  wire        ref_sel_sync;
  wire        first_ref_sync;
  wire        second_ref_sync;
  reg         sclk_prev;
  reg         sel_ref_prev;

  pin_sync #(.RESET_LEVEL(1'b0)) sync_sclk (
    .clk(MCLK), .arst_n(ARST_N), .pin_in(SCLK), .pin_out(sclk_sync)
  );
  pin_sync #(.RESET_LEVEL(1'b1)) sync_cs_n (
    .clk(MCLK), .arst_n(ARST_N), .pin_in(CS_N), .pin_out(cs_n_sync)
  );
  pin_sync #(.RESET_LEVEL(1'b0)) sync_sdi (
    .clk(MCLK), .arst_n(ARST_N), .pin_in(SDI), .pin_out(sdi_sync)
  );
  pin_sync #(.RESET_LEVEL(1'b0)) sync_ref_sel (
    .clk(MCLK), .arst_n(ARST_N), .pin_in(REF_SEL), .pin_out(ref_sel_sync)
  );
  pin_sync #(.RESET_LEVEL(1'b0)) sync_first_ref (
    .clk(MCLK), .arst_n(ARST_N), .pin_in(FIRST_REF_IN), .pin_out(first_ref_sync)
  );
  pin_sync #(.RESET_LEVEL(1'b0)) sync_second_ref (
    .clk(MCLK), .arst_n(ARST_N), .pin_in(SECOND_REF_IN), .pin_out(second_ref_sync)
  );

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_sync;
    end
  end

  wire        sclk_rise = sclk_sync & ~sclk_prev;
  wire        sclk_fall = ~sclk_sync & sclk_prev;
  wire        frame_on  = ~cs_n_sync;

  // ========================================================
  // Serial frame: 16-bit instruction then one data byte
  reg  [22:0] shift_reg;
  reg  [4:0]  bit_cnt_reg;
  reg  [7:0]  sdo_shift_reg;
  wire [23:0] frame_word = {shift_reg, sdi_sync};
  wire [14:0] frame_addr = frame_word[22:8];
  wire [7:0]  frame_data = frame_word[7:0];
  wire        wr_stb     = frame_on & sclk_rise & ~frame_word[23] &
                           (bit_cnt_reg == `FRAME_TOTAL_BITS - 5'h1);
  wire        rd_load    = frame_on & sclk_rise & frame_word[15] &
                           (bit_cnt_reg == `FRAME_INSTR_BITS - 5'h1);

  // ========================================================
  // Buffer registers
  reg  [7:0]  ref_ratio_buf_reg;
  reg         pin_override_buf_reg;
  reg         soft_select_buf_reg;
  reg  [1:0]  first_term_buf_reg;
  reg         first_reg_on_buf_reg;
  reg         first_on_buf_reg;
  reg  [1:0]  second_term_buf_reg;
  reg         second_reg_on_buf_reg;
  reg         second_on_buf_reg;
  reg  [7:0]  out1_ratio_buf_reg;

  // Active copies not brought out directly
  reg         pin_override_reg;
  reg         soft_select_reg;

  // ========================================================
  // Read-back mux
  reg  [7:0]  read_data;

  always @* begin
    read_data = 8'h00;
    case (frame_word[14:0])
      `ADDR_REF_DIVIDE_RATIO:  read_data = ref_ratio_buf_reg; // R15
      `ADDR_REF_DIVIDER_CTRL:  read_data = {5'h00, pin_override_buf_reg, soft_select_buf_reg, 1'b0};
      `ADDR_FIRST_REF_CONFIG:  read_data = {4'h0, first_term_buf_reg, first_reg_on_buf_reg, first_on_buf_reg};
      `ADDR_SECOND_REF_CONFIG: read_data = {4'h0, second_term_buf_reg, second_reg_on_buf_reg, second_on_buf_reg};
      `ADDR_OUTPUT_ONE_RATIO:  read_data = out1_ratio_buf_reg;
      default:                 read_data = 8'h00;
    endcase
  end

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      shift_reg     <= 23'h000000;
      bit_cnt_reg   <= 5'h00;
      sdo_shift_reg <= 8'h00;
      SDO           <= 1'b0;
      SDO_OE        <= 1'b0;
    end else if (!frame_on) begin
      bit_cnt_reg <= 5'h00;
      SDO_OE      <= 1'b0;
    end else begin
      if (sclk_rise) begin
        shift_reg <= frame_word[22:0];
        if (bit_cnt_reg != `FRAME_TOTAL_BITS)
          bit_cnt_reg <= bit_cnt_reg + 5'h1;
      end
      if (rd_load) begin
        sdo_shift_reg <= read_data;
        SDO           <= read_data[7];
        SDO_OE        <= 1'b1;
      end else if (sclk_fall && bit_cnt_reg > `FRAME_INSTR_BITS &&
                   bit_cnt_reg < `FRAME_TOTAL_BITS) begin
        sdo_shift_reg <= {sdo_shift_reg[6:0], 1'b0};
        SDO           <= sdo_shift_reg[6];
      end
    end
  end

  // ========================================================
  // Buffer writes, commit and live bits
  wire commit_now  = wr_stb & (frame_addr == `ADDR_COMMIT_STROBE) & frame_data[`BIT_COMMIT]; // R1 R2
  wire restart_now = wr_stb & (frame_addr == `ADDR_REF_DIVIDER_CTRL) & frame_data[`BIT_RESTART]; // R5

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ref_ratio_buf_reg     <= `RST_REF_DIVIDE_RATIO; // R4
      pin_override_buf_reg  <= 1'b1; // R6
      soft_select_buf_reg   <= 1'b1; // R7
      first_term_buf_reg    <= `TERM_DC_50_OHM; // R9
      first_reg_on_buf_reg  <= 1'b1; // R10
      first_on_buf_reg      <= 1'b1; // R10
      second_term_buf_reg   <= `TERM_DC_50_OHM; // R11
      second_reg_on_buf_reg <= 1'b1; // R12
      second_on_buf_reg     <= 1'b0; // R12
      out1_ratio_buf_reg    <= `RST_OUTPUT_ONE_RATIO; // R14
    end else if (wr_stb) begin
      case (frame_addr)
        `ADDR_REF_DIVIDE_RATIO: ref_ratio_buf_reg <= frame_data; // R4
        `ADDR_REF_DIVIDER_CTRL: begin
          pin_override_buf_reg <= frame_data[`BIT_PIN_OVERRIDE];
          soft_select_buf_reg  <= frame_data[`BIT_SOFT_SELECT];
        end
        `ADDR_FIRST_REF_CONFIG: begin
          first_term_buf_reg   <= frame_data[`TERM_MSB:`TERM_LSB]; // R9
          first_reg_on_buf_reg <= frame_data[`BIT_REGULATOR_ON]; // R10
          first_on_buf_reg     <= frame_data[`BIT_REF_ON];
        end
        `ADDR_SECOND_REF_CONFIG: begin
          second_term_buf_reg   <= frame_data[`TERM_MSB:`TERM_LSB]; // R11
          second_reg_on_buf_reg <= frame_data[`BIT_REGULATOR_ON]; // R12
          second_on_buf_reg     <= frame_data[`BIT_REF_ON];
        end
        `ADDR_OUTPUT_ONE_RATIO: out1_ratio_buf_reg <= frame_data; // R14
        default: ;
      endcase
    end
  end

  // ========================================================
  // Active control registers
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REF_DIVIDE_RATIO        <= `RST_REF_DIVIDE_RATIO;
      pin_override_reg        <= 1'b1;
      soft_select_reg         <= 1'b1;
      FIRST_REF_TERMINATION   <= `TERM_DC_50_OHM;
      FIRST_REF_REGULATOR_ON  <= 1'b1;
      FIRST_REF_ON            <= 1'b1;
      SECOND_REF_TERMINATION  <= `TERM_DC_50_OHM;
      SECOND_REF_REGULATOR_ON <= 1'b1;
      SECOND_REF_ON           <= 1'b0;
      OUTPUT_ONE_DIVIDE_RATIO <= `RST_OUTPUT_ONE_RATIO;
      OUTPUT_ONE_DIV_ENABLE   <= 1'b1;
      COMMIT_PULSE            <= 1'b0;
      REF_DIVIDER_RESTART     <= 1'b0;
    end else begin
      COMMIT_PULSE        <= commit_now; // R2
      REF_DIVIDER_RESTART <= restart_now; // R5
      if (commit_now) begin
        REF_DIVIDE_RATIO        <= ref_ratio_buf_reg; // R1
        pin_override_reg        <= pin_override_buf_reg; // R15
        soft_select_reg         <= soft_select_buf_reg;
        FIRST_REF_TERMINATION   <= first_term_buf_reg;
        FIRST_REF_REGULATOR_ON  <= first_reg_on_buf_reg;
        FIRST_REF_ON            <= first_on_buf_reg;
        SECOND_REF_TERMINATION  <= second_term_buf_reg;
        SECOND_REF_REGULATOR_ON <= second_reg_on_buf_reg;
        SECOND_REF_ON           <= second_on_buf_reg;
        OUTPUT_ONE_DIVIDE_RATIO <= out1_ratio_buf_reg;
        OUTPUT_ONE_DIV_ENABLE   <= (out1_ratio_buf_reg != 8'h00); // R14
      end
    end
  end

  // ========================================================
  // Reference selection and reference divider
  wire        sel_first = pin_override_reg ? ref_sel_sync : soft_select_reg; // R6 R7
  wire        sel_ref   = sel_first ? first_ref_sync : second_ref_sync;
  wire        ref_edge  = sel_ref & ~sel_ref_prev;
  reg  [7:0]  ref_cnt_reg;
  reg  [7:0]  ref_cnt_next;
  reg         ref_tick_next;

  always @* begin
    ref_cnt_next  = ref_cnt_reg;
    ref_tick_next = 1'b0;
    if (ref_edge) begin
      if (ref_cnt_reg + 8'h01 >= REF_DIVIDE_RATIO) begin // R4
        ref_cnt_next  = 8'h00;
        ref_tick_next = 1'b1;
      end else begin
        ref_cnt_next = ref_cnt_reg + 8'h01;
      end
    end
  end

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sel_ref_prev             <= 1'b0;
      ref_cnt_reg              <= 8'h00;
      REF_DIV_TICK             <= 1'b0;
      FIRST_REFERENCE_SELECTED <= 1'b1;
    end else begin
      sel_ref_prev             <= sel_ref;
      FIRST_REFERENCE_SELECTED <= sel_first; // R6 R7
      if (restart_now) begin
        ref_cnt_reg  <= 8'h00; // R5
        REF_DIV_TICK <= 1'b0;
      end else begin
        ref_cnt_reg  <= ref_cnt_next;
        REF_DIV_TICK <= ref_tick_next;
      end
    end
  end

endmodule // ref_select_divider_regs

// ========================================================
// Two-flop synchroniser for one asynchronous pin
module pin_sync #(
  parameter [0:0] RESET_LEVEL = 1'b0
) (
  // Clock and reset
  input  wire clk,
  input  wire arst_n,
  // Pin and its synchronised copy
  input  wire pin_in,
  output wire pin_out
);

  reg  [1:0]  sync_reg;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_reg <= {2{RESET_LEVEL}};
    end else begin
      sync_reg <= {sync_reg[0], pin_in};
    end
  end

  assign pin_out = sync_reg[1];

endmodule // pin_sync

// ===== design/ref_select_divider_regs_defs.vh
`ifndef REF_SELECT_DIVIDER_REGS_DEFS_VH
`define REF_SELECT_DIVIDER_REGS_DEFS_VH

// ==========================================================
// Register offsets (15-bit serial address)
`define ADDR_COMMIT_STROBE      15'h000f
`define ADDR_REF_DIVIDE_RATIO   15'h0010
`define ADDR_REF_DIVIDER_CTRL   15'h0011
`define ADDR_FIRST_REF_CONFIG   15'h0012
`define ADDR_SECOND_REF_CONFIG  15'h0013
`define ADDR_OUTPUT_ONE_RATIO   15'h0014

// ==========================================================
// Reset values
`define RST_COMMIT_STROBE       8'h00
`define RST_REF_DIVIDE_RATIO    8'h01
`define RST_REF_DIVIDER_CTRL    8'h06
`define RST_FIRST_REF_CONFIG    8'h07
`define RST_SECOND_REF_CONFIG   8'h06
`define RST_OUTPUT_ONE_RATIO    8'h01

// ==========================================================
// Field positions
`define BIT_COMMIT              0
`define BIT_RESTART             0
`define BIT_SOFT_SELECT         1
`define BIT_PIN_OVERRIDE        2
`define BIT_REF_ON              0
`define BIT_REGULATOR_ON        1
`define TERM_MSB                3
`define TERM_LSB                2

// ==========================================================
// Termination encodings
`define TERM_LVDS               2'h0
`define TERM_DC_50_OHM          2'h1
`define TERM_AC_COUPLED         2'h2
`define TERM_DC_HIGH_Z          2'h3

// ==========================================================
// Serial frame counts
`define FRAME_INSTR_BITS        5'h10
`define FRAME_TOTAL_BITS        5'h18

`endif

// ===== tb/ref_select_divider_regs_monitor.sv
`timescale 1ns/1ns
// =====
// Checker on the top ports
module ref_select_divider_regs_monitor (
  input wire       MCLK,
  input wire       ARST_N,
  input wire       CS_N,
  input wire       SDO_OE,
  input wire       FIRST_REF_IN,
  input wire [7:0] REF_DIVIDE_RATIO,
  input wire       FIRST_REFERENCE_SELECTED,
  input wire [1:0] FIRST_REF_TERMINATION,
  input wire       SECOND_REF_ON,
  input wire [7:0] OUTPUT_ONE_DIVIDE_RATIO,
  input wire       OUTPUT_ONE_DIV_ENABLE,
  input wire       COMMIT_PULSE,
  input wire       REF_DIVIDER_RESTART,
  input wire       REF_DIV_TICK
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  chk_commit_one_cycle: assert property (COMMIT_PULSE |=> !COMMIT_PULSE)
    else $error("commit pulse too long");
  chk_restart_one_cycle: assert property (REF_DIVIDER_RESTART |=> !REF_DIVIDER_RESTART)
    else $error("restart pulse too long");
  chk_ratio_on_commit: assert property ($changed(REF_DIVIDE_RATIO) |-> COMMIT_PULSE)
    else $error("ratio moved without commit");
  chk_term_on_commit: assert property ($changed(FIRST_REF_TERMINATION) |-> COMMIT_PULSE)
    else $error("termination moved without commit");
  chk_second_on_commit: assert property ($changed(SECOND_REF_ON) |-> COMMIT_PULSE)
    else $error("second enable moved without commit");
  chk_out1_on_commit: assert property ($changed(OUTPUT_ONE_DIVIDE_RATIO) |-> COMMIT_PULSE)
    else $error("output ratio moved without commit");
  chk_out1_enable_match: assert property (OUTPUT_ONE_DIV_ENABLE == (OUTPUT_ONE_DIVIDE_RATIO != 8'h00))
    else $error("output enable wrong");
  chk_tick_one_cycle: assert property (REF_DIV_TICK |=> !REF_DIV_TICK)
    else $error("tick too long");
  chk_tick_ratio_one: assert property (($rose(FIRST_REF_IN) && FIRST_REFERENCE_SELECTED
    && REF_DIVIDE_RATIO == 8'h01) |-> ##[2:4] (REF_DIV_TICK || REF_DIVIDER_RESTART))
    else $error("no tick at ratio one");
  chk_oe_after_frame: assert property ($rose(CS_N) |-> ##3 !SDO_OE)
    else $error("read drive left on after frame");
  cov_read_drive: cover property (SDO_OE);
  cov_commit: cover property (COMMIT_PULSE);
  cov_restart: cover property (REF_DIVIDER_RESTART);
  cov_out1_off: cover property (!OUTPUT_ONE_DIV_ENABLE);
endmodule // ref_select_divider_regs_monitor

bind ref_select_divider_regs ref_select_divider_regs_monitor i_mon (.MCLK(MCLK), .ARST_N(ARST_N),
  .CS_N(CS_N), .SDO_OE(SDO_OE),
  .FIRST_REF_IN(FIRST_REF_IN), .REF_DIVIDE_RATIO(REF_DIVIDE_RATIO),
  .FIRST_REFERENCE_SELECTED(FIRST_REFERENCE_SELECTED), .FIRST_REF_TERMINATION(FIRST_REF_TERMINATION),
  .SECOND_REF_ON(SECOND_REF_ON), .OUTPUT_ONE_DIVIDE_RATIO(OUTPUT_ONE_DIVIDE_RATIO),
  .OUTPUT_ONE_DIV_ENABLE(OUTPUT_ONE_DIV_ENABLE), .COMMIT_PULSE(COMMIT_PULSE),
  .REF_DIVIDER_RESTART(REF_DIVIDER_RESTART), .REF_DIV_TICK(REF_DIV_TICK));

// ===== tb/ref_select_divider_regs_tb_top.sv
`timescale 1ns/1ns
`include "ref_select_divider_regs_defs.vh"
module ref_select_divider_regs_tb_top;
  logic mclk, arst_n, ref_sel;
  logic ref_a = 1'b0, ref_b = 1'b0;
  time t0;
  wire sclk, cs_n, sdi, sdo, sdo_oe, sel, r1, e1, r2, e2, oen, cp, rp, tick;
  wire [7:0] ratio, o1;
  wire [1:0] t1, t2;
  int miscompares, checks, ncp, nrp, i;
  logic [31:0] lf = 32'hb4fdedda;
  logic [7:0] q, ra, rc, rb, o, er;
  logic [7:0] rst_tab [6] = '{8'h00, 8'h01, 8'h06, 8'h07, 8'h06, 8'h01};
  ref_select_divider_regs i_dut (.MCLK(mclk), .ARST_N(arst_n), .SCLK(sclk), .CS_N(cs_n), .SDI(sdi),
    .SDO(sdo), .SDO_OE(sdo_oe), .REF_SEL(ref_sel), .FIRST_REF_IN(ref_a), .SECOND_REF_IN(ref_b),
    .REF_DIVIDE_RATIO(ratio), .FIRST_REFERENCE_SELECTED(sel), .FIRST_REF_TERMINATION(t1),
    .FIRST_REF_REGULATOR_ON(r1), .FIRST_REF_ON(e1), .SECOND_REF_TERMINATION(t2),
    .SECOND_REF_REGULATOR_ON(r2), .SECOND_REF_ON(e2), .OUTPUT_ONE_DIVIDE_RATIO(o1),
    .OUTPUT_ONE_DIV_ENABLE(oen), .COMMIT_PULSE(cp), .REF_DIVIDER_RESTART(rp), .REF_DIV_TICK(tick));
  serial_host_model i_host (.MCLK(mclk), .SDO(sdo), .SCLK(sclk), .CS_N(cs_n), .SDI(sdi));
  // =====
  // Clock, references, pulse counts
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always begin
    repeat (5) @(posedge mclk);
    #1 ref_a = ~ref_a;
    ref_b = ~ref_b;
  end
  always @(posedge mclk) begin
    ncp += cp;
    nrp += rp;
  end
  // =====
  // Helpers
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [14:0] a, input logic [7:0] d);
    i_host.xfer(1'b0, a, d, q);
  endtask
  task rd(input logic [14:0] a);
    i_host.xfer(1'b1, a, 8'h00, q);
  endtask
  task tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    tally_and_finish;
  end
  // =====
  // Tests
  initial begin
    {arst_n, ref_sel} = 2'h0;
    repeat (6) @(posedge mclk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge mclk);
    chk(ratio, `RST_REF_DIVIDE_RATIO);
    chk({4'h0, t1, r1, e1}, `RST_FIRST_REF_CONFIG);
    chk({4'h0, t2, r2, e2}, `RST_SECOND_REF_CONFIG);
    chk({oen, o1[6:0]}, 8'h81);
    for (i = 0; i < 6; i++) begin
      rd(`ADDR_COMMIT_STROBE + i[14:0]);
      chk(q, rst_tab[i]);
    end
    rd(15'h0020);
    chk(q, 8'h00);
    chk({7'h0, sdo_oe}, 8'h00);
    $display("test reset done");
    er = 8'h01;
    for (i = 0; i < 4; i++) begin
      lf = nxt(lf);
      ra = (i == 0) ? 8'hff : (lf[7:0] | 8'h01);
      o = (i == 3) ? 8'h00 : lf[15:8];
      rc = {4'h0, i[1:0], lf[17:16]};
      rb = {4'h0, ~i[1:0], lf[19:18]};
      wr(`ADDR_REF_DIVIDE_RATIO, ra);
      wr(`ADDR_FIRST_REF_CONFIG, rc);
      wr(`ADDR_SECOND_REF_CONFIG, rb);
      wr(`ADDR_OUTPUT_ONE_RATIO, o);
      rd(`ADDR_REF_DIVIDE_RATIO);
      chk(q, ra);
      rd(`ADDR_FIRST_REF_CONFIG);
      chk(q, rc);
      wr(`ADDR_COMMIT_STROBE, 8'h00);
      chk(ratio, er);
      wr(`ADDR_COMMIT_STROBE, 8'h01);
      er = ra;
      chk(ratio, ra);
      chk({4'h0, t1, r1, e1}, rc);
      chk({4'h0, t2, r2, e2}, rb);
      chk(o1, o);
      chk({7'h0, oen}, {7'h0, o != 8'h00});
    end
    @(posedge tick);
    t0 = $time;
    @(posedge tick);
    chk(8'(($time - t0) / 100), er);
    $display("test staged update done");
    wr(`ADDR_REF_DIVIDE_RATIO, 8'h01);
    for (i = 0; i < 8; i++) begin
      ref_sel = i[2];
      wr(`ADDR_REF_DIVIDER_CTRL, {5'h00, i[1:0], 1'b0});
      wr(`ADDR_COMMIT_STROBE, 8'h01);
      repeat (6) @(posedge mclk);
      chk({7'h0, sel}, {7'h0, i[1] ? i[2] : i[0]});
    end
    $display("test selection done");
    wr(`ADDR_REF_DIVIDER_CTRL, 8'h07);
    rd(`ADDR_REF_DIVIDER_CTRL);
    chk(q, 8'h06);
    chk(nrp[7:0], 8'h01);
    chk(ncp[7:0], 8'h0c);
    $display("test restart done");
    tally_and_finish;
  end
endmodule // ref_select_divider_regs_tb_top

// ===== tb/serial_host_model.sv
`timescale 1ns/1ns
// =====
// Serial host
module serial_host_model (
  input  wire MCLK,
  input  wire SDO,
  output reg  SCLK,
  output reg  CS_N,
  output reg  SDI
);
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    SDI  = 1'b0;
  end
  // One frame, MSB first, data changed while clock low
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [23:0] w;
    w = {rd, a, d};
    q = 8'h00;
    @(posedge MCLK) #1 CS_N = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      SDI = w[i];
      repeat (6) @(posedge MCLK);
      #1 SCLK = 1'b1;
      if (i < 8) q[i] = SDO;
      repeat (6) @(posedge MCLK);
      #1 SCLK = 1'b0;
    end
    repeat (6) @(posedge MCLK);
    #1 CS_N = 1'b1;
    repeat (8) @(posedge MCLK);
    #1;
  endtask
endmodule // serial_host_model
